// ### src/rxc_top.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "rxc_consts.svh"
// Behaviour
// - crc type bit 0 selects 16-bit crc, 1 selects 5-bit crc; resets to 0
// - invert bit 1 compares against residue F0B8h; mode detector sets it for type B
// - invert bit 0 compares plain residue; detector clears it for type A and JIS
// - received crc is checked only when the check enable bit is set; resets 0
// - detector sets check enable for type B and JIS at 212 or 424 kbit/s
// - status 25:19 holds first collision data bit position, valid with valid flag
// - nonzero bit alignment is added into the first collision position
// - status bit 18 set on any collision during reception; resets 0
// - status bit 17 set on bad stop bit, type B SOF/EOF, byte count
// - a protocol error stops data reception for the current reception
// - protocol and integrity flags clear at the start of next reception
// - status bit 16 set on parity or crc error; reception continues
// - wrong parity used as end criterion does not set the integrity flag
// - status 15:13 gives valid bits of last byte; zero means whole byte
// - status 12:9 frame count updated on receive interrupt at each frame end, in single- and multi-frame mode
// - status 8:0 byte count valid from receive interrupt until next enable
// - preset select 5:3 picks crc start value; 001 is 6363h, 111 programmed
module rxc_top
    import rxc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`RXC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic rx_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_bit_coll,
    input wire logic rx_parity_err,
    input wire logic rx_parity_stop_en,
    input wire logic rx_proto_err,
    input wire logic rx_frame_end,
    input wire logic [8:0] rx_expected_bytes,
    input wire logic multi_frame_enable,
    input wire logic mode_det_valid,
    input wire logic [1:0] mode_det_kind,
    output logic rx_receiving,
    output logic collision_position_valid,
    output logic receive_done_interrupt,
    output logic irq
);
    rxc_top_state_t st_reg;
    rxc_top_state_t st_next;
    logic [15:0] crc16;
    logic [4:0] crc5;
    logic [15:0] preset;
    logic crc_load;
    logic bit_take;
    logic in_frame_end;
    logic crc_bad;
    logic len_bad;
    logic [8:0] final_bytes;
    logic [6:0] coll_calc;
    logic [31:0] status_word;
    logic [`RXC_NUM_EV-1:0] ev;
    logic [`RXC_NUM_EV-1:0] irq_status;
    logic [`RXC_NUM_EV-1:0] irq_mask;

    // ********************************************
    // crc preset selection and engines
    // ********************************************
    always_comb
    begin
        case (st_reg.cfg[`RXC_CFG_PSEL])
            3'h0: preset = `RXC_PRE_0;
            3'h1: preset = `RXC_PRE_1;
            3'h2: preset = `RXC_PRE_2;
            3'h3: preset = `RXC_PRE_3;
            3'h4: preset = `RXC_PRE_4;
            3'h5: preset = `RXC_PRE_5;
            3'h7: preset = st_reg.cfg[`RXC_CFG_PRESET];
            default: preset = `RXC_PRE_0; // unused code starts from zero
        endcase
    end

    // engines reload at each reception start and at each new frame in multi-frame mode
    assign in_frame_end = (st_reg.fsm == RXC_RECV) && rx_frame_end && !rx_start;
    assign crc_load = rx_start || (in_frame_end && multi_frame_enable);
    assign bit_take = (st_reg.fsm == RXC_RECV) && rx_bit_valid && !rx_start && !rx_frame_end;

    rxc_crc_lfsr #(.W(16), .POLY(`RXC_POLY16)) u_crc16
    (
        .clk(clk),
        .rst_b(rst_b),
        .load(crc_load),
        .init(preset),
        .step(bit_take),
        .din(rx_bit),
        .crc(crc16)
    );

    // the 5-bit engine only sees the low five bits of the preset
    rxc_crc_lfsr #(.W(5), .POLY(`RXC_POLY5)) u_crc5
    (
        .clk(clk),
        .rst_b(rst_b),
        .load(crc_load),
        .init(preset[4:0]),
        .step(bit_take),
        .din(rx_bit),
        .crc(crc5)
    );

    // ********************************************
    // end-of-frame checks
    // ********************************************
    always_comb
    begin
        crc_bad = 1'b0;
        if (st_reg.cfg[`RXC_CFG_EN])
        begin
            if (st_reg.cfg[`RXC_CFG_TYPE])
            begin
                crc_bad = (crc5 != `RXC_RES_5);
            end
            else if (st_reg.cfg[`RXC_CFG_INV])
            begin
                crc_bad = (crc16 != `RXC_RES_INV);
            end
            else
            begin
                crc_bad = (crc16 != `RXC_RES_PLAIN);
            end
        end
    end

    // a partly filled last byte still counts as a received byte
    assign final_bytes = st_reg.byte_cnt + {8'h00, (st_reg.bit_in_byte != 3'h0)};
    assign len_bad = (rx_expected_bytes != 9'h000) && (final_bytes != rx_expected_bytes);
    assign coll_calc = 7'(st_reg.data_bits + {4'h0, st_reg.cfg[`RXC_CFG_ALIGN]});

    // ********************************************
    // next state of the receive checker
    // ********************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.rdata = 32'h0000_0000;
        ev = '0;

        // software write to the configuration word
        if (reg_wr && (reg_addr == `RXC_CFG_IDX))
        begin
            st_next.cfg = reg_wdata & `RXC_CFG_WMASK;
        end

        // mode detector overrides, applied after a same-cycle write
        if (mode_det_valid)
        begin
            case (rxc_mode_t'(mode_det_kind))
                RXC_MODE_A:
                begin
                    st_next.cfg[`RXC_CFG_INV] = 1'b0;
                    st_next.cfg[`RXC_CFG_PSEL] = `RXC_SEL_A;
                    st_next.cfg[`RXC_CFG_PAR_EN] = 1'b1;
                    st_next.cfg[`RXC_CFG_PAR_TYPE] = 1'b1;
                end
                RXC_MODE_B:
                begin
                    st_next.cfg[`RXC_CFG_INV] = 1'b1;
                    st_next.cfg[`RXC_CFG_EN] = 1'b1;
                    st_next.cfg[`RXC_CFG_PSEL] = `RXC_SEL_B;
                end
                RXC_MODE_JIS_FAST:
                begin
                    st_next.cfg[`RXC_CFG_INV] = 1'b0;
                    st_next.cfg[`RXC_CFG_EN] = 1'b1;
                    st_next.cfg[`RXC_CFG_PSEL] = `RXC_SEL_ZERO;
                end
                default:
                begin
                    st_next.cfg[`RXC_CFG_INV] = 1'b0;
                    st_next.cfg[`RXC_CFG_PSEL] = `RXC_SEL_ZERO;
                end
            endcase
        end

        // reception start wins over protocol errors, frame ends and bits in its cycle
        if (rx_start)
        begin
            st_next.fsm = RXC_RECV;
            st_next.proto_err = 1'b0;
            st_next.integ_err = 1'b0;
            st_next.coll_det = 1'b0;
            st_next.coll_valid = 1'b0;
            st_next.coll_pos = 7'h00;
            st_next.bit_in_byte = st_reg.cfg[`RXC_CFG_ALIGN];
            st_next.byte_cnt = 9'h000;
            st_next.data_bits = 7'h00;
            st_next.num_bytes = 9'h000;
            st_next.last_bits = 3'h0;
            st_next.frames = 4'h0;
        end
        else
        begin
            case (st_reg.fsm)
                RXC_RECV:
                begin
                    if (rx_proto_err)
                    begin
                        st_next.proto_err = 1'b1;
                        st_next.fsm = RXC_STOP;
                        st_next.done = 1'b1;
                        st_next.num_bytes = final_bytes;
                    end
                    else if (rx_frame_end)
                    begin
                        if (crc_bad)
                        begin
                            st_next.integ_err = 1'b1;
                        end
                        if (len_bad)
                        begin
                            st_next.proto_err = 1'b1;
                        end
                        st_next.num_bytes = final_bytes;
                        st_next.last_bits = st_reg.bit_in_byte;
                        st_next.frames = st_reg.frames + 4'h1;
                        st_next.done = 1'b1;
                        st_next.byte_cnt = 9'h000;
                        st_next.data_bits = 7'h00;
                        st_next.bit_in_byte = st_reg.cfg[`RXC_CFG_ALIGN];
                        if (len_bad)
                        begin
                            st_next.fsm = RXC_STOP;
                        end
                        else if (!multi_frame_enable)
                        begin
                            st_next.fsm = RXC_IDLE;
                        end
                    end
                    else
                    begin
                        // parity used as end criterion is not an integrity fault
                        if (rx_parity_err && !rx_parity_stop_en)
                        begin
                            st_next.integ_err = 1'b1;
                        end
                        if (rx_bit_valid)
                        begin
                            st_next.data_bits = st_reg.data_bits + 7'h01;
                            st_next.bit_in_byte = st_reg.bit_in_byte + 3'h1;
                            if (st_reg.bit_in_byte == 3'h7)
                            begin
                                st_next.byte_cnt = st_reg.byte_cnt + 9'h001;
                            end
                            if (rx_bit_coll)
                            begin
                                st_next.coll_det = 1'b1;
                                if (!st_reg.coll_valid)
                                begin
                                    st_next.coll_valid = 1'b1;
                                    st_next.coll_pos = coll_calc;
                                end
                            end
                        end
                    end
                end
                RXC_STOP:
                begin
                    st_next.fsm = RXC_STOP; // bits ignored until the next start
                end
                default:
                begin
                    st_next.fsm = RXC_IDLE;
                end
            endcase
        end

        // the done pulse and the edges of the sticky flags feed the interrupt block
        ev[`RXC_EV_DONE] = st_next.done;
        ev[`RXC_EV_COLL] = st_next.coll_det && !st_reg.coll_det;
        ev[`RXC_EV_PROTO] = st_next.proto_err && !st_reg.proto_err;
        ev[`RXC_EV_INTEG] = st_next.integ_err && !st_reg.integ_err;

        // read data register, unmapped addresses read zero
        if (reg_rd)
        begin
            if (reg_addr == `RXC_CFG_IDX)
            begin
                st_next.rdata = st_reg.cfg;
            end
            else if (reg_addr == `RXC_STAT_IDX)
            begin
                st_next.rdata = status_word;
            end
            else if (reg_addr == `RXC_IRQ_STAT_IDX)
            begin
                st_next.rdata = {28'h000_0000, irq_status};
            end
            else if (reg_addr == `RXC_IRQ_MASK_IDX)
            begin
                st_next.rdata = {28'h000_0000, irq_mask};
            end
            else if (reg_addr == `RXC_AUX_IDX)
            begin
                st_next.rdata = {30'h0000_0000, rx_receiving, st_reg.coll_valid};
            end
        end
    end

    // ********************************************
    // state register
    // ********************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= '{cfg: `RXC_CFG_RESET, fsm: RXC_IDLE, default: '0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // status word layout, top bits reserved as zero
    assign status_word = {6'h00, st_reg.coll_pos, st_reg.coll_det, st_reg.proto_err,
        st_reg.integ_err, st_reg.last_bits, st_reg.frames, st_reg.num_bytes};

    rxc_irq u_irq
    (
        .clk(clk),
        .rst_b(rst_b),
        .evt(ev),
        .rd_clr(reg_rd && (reg_addr == `RXC_IRQ_STAT_IDX)),
        .wr_mask(reg_wr && (reg_addr == `RXC_IRQ_MASK_IDX)),
        .wdata(reg_wdata[`RXC_NUM_EV-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    assign reg_rdata = st_reg.rdata;
    assign rx_receiving = (st_reg.fsm == RXC_RECV);
    assign collision_position_valid = st_reg.coll_valid;
    assign receive_done_interrupt = st_reg.done;

    // ********************************************
    // checks
    // ********************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_start_clears_err: assert property (rx_start |=> !st_reg.proto_err && !st_reg.integ_err)
        else $error("errors not cleared at reception start");
    a_proto_stops_rx: assert property ((st_reg.fsm == RXC_RECV) && rx_proto_err && !rx_start
        |=> st_reg.proto_err && (st_reg.fsm == RXC_STOP) ##1 (st_reg.fsm == RXC_STOP))
        else $error("protocol error did not stop reception");
    a_stop_no_bits: assert property ((st_reg.fsm == RXC_STOP) && !rx_start
        |=> $stable(st_reg.data_bits) && $stable(st_reg.byte_cnt))
        else $error("bits taken after protocol error");
    a_coll_first_pos: assert property (bit_take && rx_bit_coll && !st_reg.coll_valid
        |=> st_reg.coll_det && st_reg.coll_valid
        && st_reg.coll_pos == 7'($past(st_reg.data_bits) + $past(st_reg.cfg[8:6])))
        else $error("first collision position wrong");
    a_parity_stop_quiet: assert property ((st_reg.fsm == RXC_RECV) && rx_parity_err
        && rx_parity_stop_en && !rx_frame_end && !rx_start && !rx_proto_err
        |=> st_reg.integ_err == $past(st_reg.integ_err))
        else $error("integrity flag set for parity end criterion");
    a_mode_b_cfg: assert property (mode_det_valid && mode_det_kind == 2'h1
        |=> st_reg.cfg[1] && st_reg.cfg[0])
        else $error("type B detection did not set invert and enable");
    a_mode_a_cfg: assert property (mode_det_valid && mode_det_kind == 2'h0
        |=> !st_reg.cfg[1] && st_reg.cfg[5:3] == 3'h1)
        else $error("type A detection did not clear invert");
    a_crc_off_quiet: assert property (in_frame_end && !st_reg.cfg[0] && !st_reg.integ_err
        |=> !st_reg.integ_err)
        else $error("crc checked while disabled");
    a_frames_count: assert property (in_frame_end && !rx_proto_err
        |=> receive_done_interrupt && st_reg.frames == $past(st_reg.frames) + 4'h1)
        else $error("frame count not updated with receive interrupt");
    a_crc16_residue: assert property (in_frame_end && !rx_proto_err && st_reg.cfg[0]
        && !st_reg.cfg[2] && st_reg.cfg[1] && crc16 != 16'hF0B8 |=> st_reg.integ_err)
        else $error("inverted residue mismatch not flagged");

endmodule // rxc_top

// ### src/rxc_consts.svh
`ifndef RXC_CONSTS_SVH
`define RXC_CONSTS_SVH

// ********************************************
// register offsets (word index on the plain port)
// ********************************************
`define RXC_ADDR_W 16
`define RXC_CFG_IDX 16'h0012
`define RXC_STAT_IDX 16'h0013
`define RXC_IRQ_STAT_IDX 16'h0020
`define RXC_IRQ_MASK_IDX 16'h0021
`define RXC_AUX_IDX 16'h0022

// ********************************************
// configuration word layout and reset
// ********************************************
`define RXC_CFG_RESET 32'h0000_0000
`define RXC_CFG_WMASK 32'hFFFF_0FFF
`define RXC_CFG_EN 0
`define RXC_CFG_INV 1
`define RXC_CFG_TYPE 2
`define RXC_CFG_PSEL 5:3
`define RXC_CFG_ALIGN 8:6
`define RXC_CFG_PAR_EN 10
`define RXC_CFG_PAR_TYPE 11
`define RXC_CFG_PRESET 31:16

// ********************************************
// crc presets, residues and polynomials
// ********************************************
`define RXC_SEL_ZERO 3'h0
`define RXC_SEL_A 3'h1
`define RXC_SEL_B 3'h3
`define RXC_PRE_0 16'h0000
`define RXC_PRE_1 16'h6363
`define RXC_PRE_2 16'hA671
`define RXC_PRE_3 16'hFFFF
`define RXC_PRE_4 16'h0012
`define RXC_PRE_5 16'hE012
`define RXC_RES_INV 16'hF0B8
`define RXC_RES_PLAIN 16'h0000
`define RXC_RES_5 5'h00
`define RXC_POLY16 16'h8408
`define RXC_POLY5 5'h12

// ********************************************
// interrupt event bits
// ********************************************
`define RXC_NUM_EV 4
`define RXC_EV_DONE 0
`define RXC_EV_COLL 1
`define RXC_EV_PROTO 2
`define RXC_EV_INTEG 3

`endif

// ### src/rxc_pkg.sv
package rxc_pkg;

    typedef enum logic [2:0] {
        RXC_IDLE = 3'h1,
        RXC_RECV = 3'h2,
        RXC_STOP = 3'h4
    } rxc_state_t;

    typedef enum logic [1:0] {
        RXC_MODE_A = 2'h0,
        RXC_MODE_B = 2'h1,
        RXC_MODE_JIS_FAST = 2'h2,
        RXC_MODE_JIS_SLOW = 2'h3
    } rxc_mode_t;

    typedef struct packed {
        logic [31:0] cfg;
        rxc_state_t fsm;
        logic [2:0] bit_in_byte;
        logic [8:0] byte_cnt;
        logic [6:0] data_bits;
        logic [6:0] coll_pos;
        logic coll_valid;
        logic coll_det;
        logic proto_err;
        logic integ_err;
        logic [2:0] last_bits;
        logic [3:0] frames;
        logic [8:0] num_bytes;
        logic done;
        logic [31:0] rdata;
    } rxc_top_state_t;

    typedef struct packed {
        logic [3:0] status;
        logic [3:0] mask;
    } rxc_irq_state_t;

endpackage

// ### src/rxc_crc_lfsr.sv
`timescale 1ns/1ps
module rxc_crc_lfsr
#(
    parameter int W = 16,
    parameter logic [W-1:0] POLY = '1
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [W-1:0] init,
    input wire logic step,
    input wire logic din,
    output logic [W-1:0] crc
);
    logic [W-1:0] crc_reg;
    logic [W-1:0] crc_next;

    // ********************************************
    // reflected serial lfsr, lsb first
    // ********************************************
    always_comb
    begin
        crc_next = crc_reg;
        if (load)
        begin
            crc_next = init;
        end
        else if (step)
        begin
            crc_next = (crc_reg >> 1) ^ ({W{crc_reg[0] ^ din}} & POLY);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            crc_reg <= '0;
        end
        else
        begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;

endmodule // rxc_crc_lfsr

// ### src/rxc_irq.sv
`timescale 1ns/1ps
`include "rxc_consts.svh"
module rxc_irq
    import rxc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`RXC_NUM_EV-1:0] evt,
    input wire logic rd_clr,
    input wire logic wr_mask,
    input wire logic [`RXC_NUM_EV-1:0] wdata,
    output logic [`RXC_NUM_EV-1:0] status,
    output logic [`RXC_NUM_EV-1:0] mask,
    output logic irq
);
    rxc_irq_state_t st_reg;
    rxc_irq_state_t st_next;

    // ********************************************
    // sticky status, read clears, a new event wins over the clear
    // ********************************************
    always_comb
    begin
        st_next = st_reg;
        if (rd_clr)
        begin
            st_next.status = '0;
        end
        st_next.status = st_next.status | evt;
        if (wr_mask)
        begin
            st_next.mask = wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign status = st_reg.status;
    assign mask = st_reg.mask;
    assign irq = |(st_reg.status & st_reg.mask); // level, unmasked sticky bit

endmodule // rxc_irq

// ### test/rxc_card.sv
`timescale 1ns/1ps
// ********************************************
// card side: serial bits toward the decoder
// ********************************************
module rxc_card
(
    input wire logic clk,
    output logic rx_bit_valid,
    output logic rx_bit,
    output logic rx_bit_coll,
    output logic rx_frame_end
);
    // quiet line at time zero
    initial
    begin
        rx_bit_valid = 1'h0;
        rx_bit = 1'h0;
        rx_bit_coll = 1'h0;
        rx_frame_end = 1'h0;
    end

    // lsb first; gap idle cycles before each bit model a slow card, and an idle
    // data line toggles so that a stale bit can never pass for fresh data
    task automatic send(input logic [31:0] d, input int n, input int c, input int gap,
        input bit fin);
        for (int i = 0; i < n; i++)
        begin
            repeat (gap)
            begin
                @(posedge clk);
                rx_bit_valid <= 1'h0;
                rx_bit <= ~rx_bit;
            end
            @(posedge clk);
            rx_bit_valid <= 1'h1;
            rx_bit <= d[i];
            rx_bit_coll <= (i == c);
        end
        @(posedge clk);
        rx_bit_valid <= 1'h0;
        rx_bit <= ~rx_bit;
        rx_bit_coll <= 1'h0;
        // frame end one idle cycle after the last bit
        if (fin)
        begin
            @(posedge clk);
            rx_frame_end <= 1'h1;
            @(posedge clk);
            rx_frame_end <= 1'h0;
        end
    endtask
endmodule // rxc_card

// ### test/tb_rx_crc_check_and_status.sv
`timescale 1ns/1ps
`include "rxc_consts.svh"
module tb_rx_crc_check_and_status
    import rxc_pkg::*;
;
    // ********************************************
    // rows, signals and instances
    // ********************************************
    localparam logic [31:0] CFG [9] = '{32'h0000_0001, 32'h0000_001B, 32'h0000_0010,
        32'h0000_001B, 32'h0000_001D, 32'h0000_002D, 32'h0000_0009, 32'hABCD_0039,
        32'h0000_0021};
    localparam logic [8:0] BAD = 9'h126;
    localparam logic [15:0] PRE [8] = '{`RXC_PRE_0, `RXC_PRE_1, `RXC_PRE_2, `RXC_PRE_3,
        `RXC_PRE_4, `RXC_PRE_5, 16'h0000, 16'h0000};
    localparam logic [7:0] MD = 8'h1C;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'h0, reg_rd = 1'h0, rx_start = 1'h0, rx_parity_err = 1'h0;
    logic rx_parity_stop_en = 1'h0, rx_proto_err = 1'h0, mode_det_valid = 1'h0;
    logic [1:0] mode_det_kind = 2'h0;
    logic [8:0] rx_expected_bytes = 9'h000;
    logic multi_frame_enable = 1'h0;
    logic [31:0] reg_rdata, q, c;
    logic [15:0] d, p, x;
    logic rx_bit_valid, rx_bit, rx_bit_coll, rx_frame_end, rx_receiving, irq;
    logic collision_position_valid, receive_done_interrupt;
    int err_total = 0, checked = 0, cyc = 0;

    rxc_top uut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_start,
        .rx_bit_valid, .rx_bit, .rx_bit_coll, .rx_parity_err, .rx_parity_stop_en, .rx_proto_err,
        .rx_frame_end, .rx_expected_bytes, .multi_frame_enable, .mode_det_valid,
        .mode_det_kind, .rx_receiving, .collision_position_valid, .receive_done_interrupt, .irq);
    rxc_card card (.clk, .rx_bit_valid, .rx_bit, .rx_bit_coll, .rx_frame_end);

    // clock, and a cycle ceiling well above the several hundred the tests need
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            err_total++;
            stop_test();
        end
    end

    // ********************************************
    // helpers
    // ********************************************
    task stop_test();
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task chk1(input string n, input logic e, input logic g);
        chk(n, {31'h0000_0000, e}, {31'h0000_0000, g});
    endtask
    task wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 q = reg_rdata;
    endtask
    task start();
        @(posedge clk);
        rx_start <= 1'h1;
        @(posedge clk);
        rx_start <= 1'h0;
    endtask
    // reflected crc, register shifts right; 5-bit keeps only the low five bits
    function automatic logic [15:0] crc(input logic [15:0] s, input logic f,
        input logic [15:0] b);
        logic [15:0] r;
        r = f ? {11'h000, s[4:0]} : s;
        for (int i = 0; i < 16; i++)
        begin
            r = (r >> 1) ^ ((r[0] ^ b[i]) ? (f ? 16'h0012 : 16'h8408) : 16'h0000);
        end
        return r;
    endfunction

    // ********************************************
    // table of frames, then reset and awkward cases
    // ********************************************
    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        for (int i = 0; i < 9; i++)
        begin
            c = CFG[i];
            d = 16'h5A3C ^ (16'h1111 * i[15:0]);
            p = (c[5:3] == 3'h7) ? c[31:16] : PRE[c[5:3]];
            x = crc(p, c[2], d);
            x = (c[1] ? ~x : x) ^ {15'h0000, BAD[i]};
            wr(`RXC_CFG_IDX, c);
            start();
            #1 chk1("receiving", 1'h1, rx_receiving);
            card.send({x, d}, c[2] ? 21 : 32, -1, 0, 1);
            #1 chk1("done", 1'h1, receive_done_interrupt);
            chk1("masked irq", 1'h0, irq);
            rd(`RXC_STAT_IDX);
            chk("status", {15'h0000, c[0] & BAD[i], c[2] ? 3'h5 : 3'h0, 4'h1,
                c[2] ? 9'h003 : 9'h004}, q);
        end
        @(posedge clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk1("reset irq", 1'h0, irq);
        chk1("reset receiving", 1'h0, rx_receiving);
        @(posedge clk) rst_b <= 1'h1;
        rd(`RXC_CFG_IDX);
        chk("reset cfg", 32'h0000_0000, q);
        rd(`RXC_STAT_IDX);
        chk("reset status", 32'h0000_0000, q);
        // collision with bit alignment two, interrupt unmasked
        wr(`RXC_IRQ_MASK_IDX, 32'h0000_0001);
        wr(`RXC_CFG_IDX, 32'h0000_0080);
        start();
        multi_frame_enable <= 1'h1;
        repeat (2) card.send(32'h0000_F0F0, 16, 5, 0, 1);
        #1 chk1("coll valid", 1'h1, collision_position_valid);
        rd(`RXC_STAT_IDX);
        chk("coll", 32'h003C_0400, q & 32'h03FC_1E00);
        chk1("irq", 1'h1, irq);
        rd(`RXC_IRQ_STAT_IDX);
        chk("irq status", 32'h0000_0001, q & 32'h0000_0001);
        chk1("irq cleared", 1'h0, irq);
        rd(16'h0030);
        chk("unmapped", 32'h0000_0000, q);
        // protocol error in mid-frame, later bits must be dropped
        wr(`RXC_CFG_IDX, 32'h0000_0000);
        multi_frame_enable <= 1'h0;
        start();
        card.send(32'h0000_00A5, 8, -1, 0, 0);
        @(posedge clk);
        rx_proto_err <= 1'h1;
        @(posedge clk);
        rx_proto_err <= 1'h0;
        #1 chk1("proto done", 1'h1, receive_done_interrupt);
        card.send(32'h0000_FFFF, 8, -1, 0, 1);
        rd(`RXC_STAT_IDX);
        chk("proto", 32'h0002_0001, q & 32'h0003_E1FF);
        // parity error with and without reversed parity as end criterion, slow card
        for (int k = 0; k < 2; k++)
        begin
            start();
            rx_parity_stop_en <= k[0];
            rx_expected_bytes <= 9'(3 * k);
            rd(`RXC_STAT_IDX);
            chk("flags cleared", 32'h0000_0000, q & 32'h0003_0000);
            @(posedge clk);
            rx_parity_err <= 1'h1;
            @(posedge clk);
            rx_parity_err <= 1'h0;
            card.send(32'h0000_1234, 16, -1, 2, 1);
            rd(`RXC_STAT_IDX);
            chk("parity", {14'h0000, k[0], ~k[0], 16'h0002}, q & 32'h0003_01FF);
        end
        // each mode detector result against a preset of invert only
        for (int k = 0; k < 4; k++)
        begin
            wr(`RXC_CFG_IDX, 32'h0000_0002);
            @(posedge clk);
            mode_det_valid <= 1'h1;
            mode_det_kind <= k[1:0];
            @(posedge clk);
            mode_det_valid <= 1'h0;
            rd(`RXC_CFG_IDX);
            chk("mode", {30'h0000_0000, MD[2 * k +: 2]}, q & 32'h0000_0003);
        end
        stop_test();
    end
endmodule // tb_rx_crc_check_and_status
